/* rtl/vsr_ctrl.sv */
`timescale 1ns/1ns
module vsr_ctrl #(
  parameter int ADDR_W = vsr_pkg::ADDR_W,
  parameter int REF_CYC_SHORT = vsr_pkg::REF_CYC_SHORT,
  parameter int REF_CYC_LONG = vsr_pkg::REF_CYC_LONG
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [ADDR_W-1:0] row_addr_in,
  input wire logic [ADDR_W-1:0] col_addr_in,
  input wire logic access_req_in,
  input wire logic write_in,
  input wire logic shift_reg_load_req_in,
  input wire logic [3:0] row_sel_in,
  input wire logic [3:0] col_sel_in,
  input wire logic col_enable_first_n_in,
  input wire logic program_load_n_in,
  input wire logic refresh_inhibit_n_in,
  input wire logic refresh_request_n_in,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [3:0] row_strobe_n_out,
  output logic [3:0] col_strobe_n_out,
  output logic transfer_output_enable_n_out,
  output logic refresh_status_n_out,
  output logic access_busy_out
);
  // Refresh and programming control pins pass two flops before use
  logic [1:0] inh_sync, req_sync, ml_sync, ecas_sync;
  logic inhibit_n, request_n, ml_n, ecas_n;
  always_ff @(posedge clock_in) begin
    inh_sync <= {inh_sync[0], refresh_inhibit_n_in};
    req_sync <= {req_sync[0], refresh_request_n_in};
    ml_sync <= {ml_sync[0], program_load_n_in};
    ecas_sync <= {ecas_sync[0], col_enable_first_n_in};
  end
  assign inhibit_n = inh_sync[1];
  assign request_n = req_sync[1];
  assign ml_n = ml_sync[1];
  assign ecas_n = ecas_sync[1];

  // Programming latch, open only while load is low
  logic mode_active_flag;
  logic interval_long;
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      mode_active_flag <= 1'b0;
      interval_long <= 1'b0;
    end else if (!ml_n) begin // see R14
      mode_active_flag <= !ecas_n; // see R9
      interval_long <= row_addr_in[vsr_pkg::INTERVAL_SEL_BIT]; // see R15
    end
  end

  // Interval timer; a single tick pulse marks refresh due
  logic [15:0] ref_timer;
  logic [15:0] ref_limit;
  wire ref_tick = (ref_timer == 16'h0000);
  assign ref_limit = interval_long ? 16'(REF_CYC_LONG - 1) : 16'(REF_CYC_SHORT - 1); // see R15
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ref_timer <= 16'(REF_CYC_SHORT - 1);
    end else if (ref_tick) begin
      ref_timer <= ref_limit; // see R10
    end else begin
      ref_timer <= ref_timer - 16'h0001;
    end
  end

  // Pending refresh: tick (inhibit negated) or external request sets, start clears; set wins
  logic ref_pending;
  logic [ADDR_W-1:0] ref_row;
  logic is_write, is_xfer, state_was_ref;
  vsr_pkg::vsr_state_t state, next_state;
  wire start_ref = (state == vsr_pkg::VSR_IDLE) && ref_pending;
  wire ext_req = !request_n && !inhibit_n; // see R12
  wire clear_row = !request_n && inhibit_n; // see R13
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ref_pending <= 1'b0;
    end else if ((ref_tick && inhibit_n) || ext_req) begin // see R11
      ref_pending <= 1'b1;
    end else if (start_ref) begin
      ref_pending <= 1'b0;
    end
  end

  // Refresh row counter; cleared by request when refresh enabled
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      ref_row <= '0;
    end else if (clear_row) begin // see R13
      ref_row <= '0;
    end else if (state == vsr_pkg::VSR_PRE && state_was_ref) begin
      ref_row <= ref_row + 1'b1;
    end
  end

  // Access attributes latched at start
  logic [3:0] row_sel, col_sel;
  wire start_acc = (state == vsr_pkg::VSR_IDLE) && !ref_pending && access_req_in;
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      is_write <= 1'b0;
      is_xfer <= 1'b0;
      state_was_ref <= 1'b0;
      row_sel <= 4'h0;
      col_sel <= 4'h0;
    end else if (start_acc) begin
      is_write <= write_in;
      is_xfer <= shift_reg_load_req_in;
      state_was_ref <= 1'b0;
      row_sel <= row_sel_in;
      col_sel <= col_sel_in;
    end else if (start_ref) begin
      is_xfer <= 1'b0; // Stale transfer flag must not colour a refresh
      state_was_ref <= 1'b1;
    end
  end

  // Sequencer: pending refresh beats a new access in idle; an access held in OE delays it
  always_comb begin
    next_state = state;
    case (state)
      vsr_pkg::VSR_IDLE: begin
        if (ref_pending) next_state = vsr_pkg::VSR_REF;
        else if (access_req_in) next_state = vsr_pkg::VSR_ROW;
      end
      vsr_pkg::VSR_ROW: next_state = vsr_pkg::VSR_COL;
      vsr_pkg::VSR_COL: next_state = vsr_pkg::VSR_OE;
      vsr_pkg::VSR_OE: begin
        if (!access_req_in) next_state = vsr_pkg::VSR_DROP;
      end
      vsr_pkg::VSR_DROP: next_state = vsr_pkg::VSR_PRE;
      vsr_pkg::VSR_REF: next_state = vsr_pkg::VSR_PRE;
      vsr_pkg::VSR_PRE: next_state = vsr_pkg::VSR_IDLE;
      default: next_state = vsr_pkg::VSR_IDLE;
    endcase
  end
  always_ff @(posedge clock_in) begin
    if (!resetn_in) state <= vsr_pkg::VSR_IDLE;
    else state <= next_state;
  end

  // Strobe decode; transfer strobe falls one cycle before row strobe and rises before it
  vsr_pkg::vsr_strobes_t next_str, str;
  logic [ADDR_W-1:0] next_addr;
  wire in_acc = (state == vsr_pkg::VSR_ROW) || (state == vsr_pkg::VSR_COL) || (state == vsr_pkg::VSR_OE);
  wire ras_on = in_acc || (state == vsr_pkg::VSR_REF);
  wire cas_on = (state == vsr_pkg::VSR_COL) || (state == vsr_pkg::VSR_OE);
  wire xfer_oe = (start_acc && shift_reg_load_req_in) ||
                 (is_xfer && (state == vsr_pkg::VSR_ROW || state == vsr_pkg::VSR_COL)); // see R6
  wire read_oe = !is_write && !is_xfer && (state == vsr_pkg::VSR_OE || state == vsr_pkg::VSR_DROP); // see R8
  assign next_str.row_strobe_n = ras_on ? ~(state == vsr_pkg::VSR_REF ? 4'hF : row_sel) : vsr_pkg::STROBE_IDLE; // see R3
  assign next_str.col_strobe_n = (cas_on && !is_xfer) ? ~col_sel : vsr_pkg::STROBE_IDLE; // see R5
  assign next_str.transfer_output_enable_n = !(xfer_oe || read_oe); // see R7
  assign next_addr = (state == vsr_pkg::VSR_REF) ? ref_row : // see R2
                     (cas_on ? col_addr_in : row_addr_in); // see R1

  // Registered outputs, one cycle after the state; busy comes straight from the state
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      str <= '{vsr_pkg::STROBE_IDLE, vsr_pkg::STROBE_IDLE, 1'b1};
      mem_addr_out <= '0;
      refresh_status_n_out <= 1'b1;
    end else begin
      str <= next_str; // see R4
      mem_addr_out <= next_addr;
      if (mode_active_flag) begin // see R9
        refresh_status_n_out <= !(start_ref || state == vsr_pkg::VSR_REF ||
                                  (state == vsr_pkg::VSR_PRE && state_was_ref));
      end else begin
        refresh_status_n_out <= !(ref_pending || ref_tick); // see R10
      end
    end
  end
  assign row_strobe_n_out = str.row_strobe_n;
  assign col_strobe_n_out = str.col_strobe_n;
  assign transfer_output_enable_n_out = str.transfer_output_enable_n;
  assign access_busy_out = (state != vsr_pkg::VSR_IDLE);

  property p_ref_addr;
    @(posedge clock_in) disable iff (!resetn_in)
      state == vsr_pkg::VSR_REF |=> mem_addr_out == $past(ref_row) && row_strobe_n_out == 4'h0;
  endproperty
  a_ref_addr: assert property (p_ref_addr) else $error("refresh address or strobe wrong"); // see R2
  property p_write_oe;
    @(posedge clock_in) disable iff (!resetn_in)
      (in_acc && is_write && !is_xfer) |=> transfer_output_enable_n_out;
  endproperty
  a_write_oe: assert property (p_write_oe) else $error("write drove output enable"); // see R7
  property p_read_oe;
    @(posedge clock_in) disable iff (!resetn_in)
      $fell(transfer_output_enable_n_out) && !is_xfer |-> col_strobe_n_out != 4'hF || col_sel == 4'h0;
  endproperty
  a_read_oe: assert property (p_read_oe) else $error("output enable before column strobe"); // see R8
  property p_xfer;
    @(posedge clock_in) disable iff (!resetn_in)
      $fell(row_strobe_n_out[0]) && is_xfer |-> !transfer_output_enable_n_out && $past(!transfer_output_enable_n_out);
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer strobe late"); // see R6
  property p_due;
    @(posedge clock_in) disable iff (!resetn_in)
      ref_tick && inhibit_n |=> ref_pending ##[1:20] state == vsr_pkg::VSR_REF;
  endproperty
  a_due: assert property (p_due) else $error("due refresh not run"); // see R11
  property p_ml;
    @(posedge clock_in) disable iff (!resetn_in)
      ml_n |=> $stable(mode_active_flag) && $stable(interval_long);
  endproperty
  a_ml: assert property (p_ml) else $error("programming changed without load"); // see R14
  property p_clr;
    @(posedge clock_in) disable iff (!resetn_in)
      clear_row |=> ref_row == '0;
  endproperty
  a_clr: assert property (p_clr) else $error("row counter not cleared"); // see R13
  property p_refresh_due_flag;
    @(posedge clock_in) disable iff (!resetn_in)
      !mode_active_flag && ref_tick |=> !refresh_status_n_out;
  endproperty
  a_refresh_due_flag: assert property (p_refresh_due_flag) else $error("refresh due not signalled"); // see R10

  // Row address follows the host row while the row strobe is set up
  property p_addr_row;
    @(posedge clock_in) disable iff (!resetn_in)
      state == vsr_pkg::VSR_ROW |=> mem_addr_out == $past(row_addr_in);
  endproperty
  a_addr_row: assert property (p_addr_row) else $error("row address not on bus"); // see R1

  // Column address replaces it once the column phase starts
  property p_addr_col;
    @(posedge clock_in) disable iff (!resetn_in)
      state == vsr_pkg::VSR_COL |=> mem_addr_out == $past(col_addr_in);
  endproperty
  a_addr_col: assert property (p_addr_col) else $error("column address not on bus"); // see R1

  // Column strobe only ever follows an open row, except when row_sel is 4'h0 and no row strobe asserts
  property p_ras_before_cas;
    @(posedge clock_in) disable iff (!resetn_in)
      col_strobe_n_out != 4'hF |-> $past(row_strobe_n_out) != 4'hF || row_sel == 4'h0;
  endproperty
  a_ras_before_cas: assert property (p_ras_before_cas) else $error("column strobe without row"); // see R5

  // Refresh never strobes a column
  property p_ref_no_cas;
    @(posedge clock_in) disable iff (!resetn_in)
      state == vsr_pkg::VSR_REF |=> col_strobe_n_out == 4'hF;
  endproperty
  a_ref_no_cas: assert property (p_ref_no_cas) else $error("column strobe in refresh"); // see R4

  // Strobes close as the access drops, leaving precharge clean
  property p_precharge;
    @(posedge clock_in) disable iff (!resetn_in)
      state == vsr_pkg::VSR_DROP |=> row_strobe_n_out == 4'hF && col_strobe_n_out == 4'hF;
  endproperty
  a_precharge: assert property (p_precharge) else $error("strobes open after drop"); // see R3

  // Transfer cycles keep column strobes idle
  property p_xfer_no_cas;
    @(posedge clock_in) disable iff (!resetn_in)
      is_xfer && in_acc |=> col_strobe_n_out == 4'hF;
  endproperty
  a_xfer_no_cas: assert property (p_xfer_no_cas) else $error("column strobe in transfer"); // see R6

  // Read enable lets go only after the column strobe has
  property p_read_release;
    @(posedge clock_in) disable iff (!resetn_in)
      $rose(transfer_output_enable_n_out) && !is_xfer |-> $past(col_strobe_n_out) == 4'hF;
  endproperty
  a_read_release: assert property (p_read_release) else $error("output enable released early"); // see R8

  // Flag mode holds status low through the refresh beat
  property p_flag_hold;
    @(posedge clock_in) disable iff (!resetn_in)
      mode_active_flag && state == vsr_pkg::VSR_REF |=> !refresh_status_n_out;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("refresh flag missing"); // see R9

  // Flag mode status negates only with all row strobes idle
  property p_flag_release;
    @(posedge clock_in) disable iff (!resetn_in)
      mode_active_flag && $rose(refresh_status_n_out) |-> row_strobe_n_out == 4'hF;
  endproperty
  a_flag_release: assert property (p_flag_release) else $error("refresh flag dropped early"); // see R9

  // Held external request chains refreshes back to back
  property p_burst;
    @(posedge clock_in) disable iff (!resetn_in)
      ext_req && state == vsr_pkg::VSR_PRE |-> ##2 state == vsr_pkg::VSR_REF;
  endproperty
  a_burst: assert property (p_burst) else $error("burst refresh broken"); // see R13

  // Load window copies the first column enable into the mode
  property p_ml_load;
    @(posedge clock_in) disable iff (!resetn_in)
      !ml_n |=> mode_active_flag == !$past(ecas_n);
  endproperty
  a_ml_load: assert property (p_ml_load) else $error("mode not captured at load"); // see R14

  // Timer reloads with the programmed interval
  property p_interval;
    @(posedge clock_in) disable iff (!resetn_in)
      ref_tick |=> ref_timer == $past(ref_limit);
  endproperty
  a_interval: assert property (p_interval) else $error("interval reload wrong"); // see R15
  c_ref: cover property (@(posedge clock_in) state == vsr_pkg::VSR_REF);
  c_read: cover property (@(posedge clock_in) read_oe);
  c_xfer: cover property (@(posedge clock_in) xfer_oe);
  c_clear: cover property (@(posedge clock_in) clear_row);
  c_burst: cover property (@(posedge clock_in) state == vsr_pkg::VSR_REF ##3 state == vsr_pkg::VSR_REF);
endmodule

/* rtl/vsr_pkg.sv */
// Overview of operation
// R1: Memory address outputs multiplex row and column address inputs.
// R2: During refresh the refresh row counter drives the memory address.
// R3: Four row strobes assert so the memory captures the row address.
// R4: Row strobes also capture the refresh row address during refresh.
// R5: Four column strobes assert so the memory captures the column address.
// R6: Transfer cycle drives transfer/output-enable low before row strobe falls, high before rise.
// R7: Ordinary write keeps transfer/output-enable high throughout.
// R8: Read asserts transfer/output-enable after column strobe, releases after column strobe releases.
// R9: First column enable asserted at programming: status output flags refresh active.
// R10: First column enable negated at programming: status output requests refresh every interval.
// R11: Due refresh with inhibit negated runs internally as soon as arbitration allows.
// R12: With inhibit asserted the outside system owns refresh via the request input.
// R13: Request with inhibit gives burst refreshes; without inhibit clears the row counter.
// R14: Programming choices are captured only while program load is low.
// R15: A programming bit chosen at load selects the 13 or 15 microsecond interval.
package vsr_pkg;
  localparam int ADDR_W = 11;
  localparam int REF_NS_SHORT = 13000;
  localparam int REF_NS_LONG = 15000;
  localparam int CLK_NS = 4;
  localparam int REF_CYC_SHORT = REF_NS_SHORT / CLK_NS;
  localparam int REF_CYC_LONG = REF_NS_LONG / CLK_NS;
  localparam int INTERVAL_SEL_BIT = 0;
  localparam logic [3:0] STROBE_IDLE = 4'hF;
  localparam logic [3:0] STROBE_ALL = 4'h0;

  typedef enum logic [6:0] {
    VSR_IDLE = 7'h01,
    VSR_ROW = 7'h02,
    VSR_COL = 7'h04,
    VSR_OE = 7'h08,
    VSR_DROP = 7'h10,
    VSR_REF = 7'h20,
    VSR_PRE = 7'h40
  } vsr_state_t;

  typedef struct packed {
    logic [3:0] row_strobe_n;
    logic [3:0] col_strobe_n;
    logic transfer_output_enable_n;
  } vsr_strobes_t;
endpackage

/* testbench/vsr_vram_model.sv */
`timescale 1ns/1ns
// Array side: latches row and column like a real part, and flags output-enable misuse
module vsr_vram_model (
  input wire logic clock_in,
  input wire logic clr_in,
  input wire logic [vsr_pkg::ADDR_W-1:0] mem_addr_in,
  input wire logic [3:0] row_strobe_n_in,
  input wire logic [3:0] col_strobe_n_in,
  input wire logic oe_n_in,
  output logic [vsr_pkg::ADDR_W-1:0] row_out,
  output logic [vsr_pkg::ADDR_W-1:0] col_out,
  output logic oe_at_fall_out,
  output logic oe_at_rise_out,
  output logic oe_low_out,
  output logic oe_fault_out
);
  logic [3:0] prev_row;
  logic [3:0] prev_col;
  logic prev_oe;

  // Edge detection one cycle late, so the captured address is the one beside the edge
  always_ff @(posedge clock_in) begin
    prev_row <= row_strobe_n_in;
    prev_col <= col_strobe_n_in;
    prev_oe <= oe_n_in;
    if (prev_row == 4'hF && row_strobe_n_in != 4'hF) begin
      row_out <= mem_addr_in;
      oe_at_fall_out <= prev_oe; // Enable level one cycle before the strobe edge
    end
    if (prev_col == 4'hF && col_strobe_n_in != 4'hF) begin
      col_out <= mem_addr_in;
    end
    if (prev_row != 4'hF && row_strobe_n_in == 4'hF) begin
      oe_at_rise_out <= prev_oe;
    end
    if (clr_in) begin
      oe_low_out <= 1'b0;
      oe_fault_out <= 1'b0;
    end else begin
      if (!oe_n_in) begin
        oe_low_out <= 1'b1;
      end
      // Enable falling with row open but no column strobe yet is an early drive
      // Same-cycle moves count as faults too, so compare against the previous column level
      if ((prev_oe && !oe_n_in && prev_col == 4'hF && row_strobe_n_in != 4'hF) ||
          (!prev_oe && oe_n_in && prev_col != 4'hF)) begin
        oe_fault_out <= 1'b1;
      end
    end
  end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic clock_in = 0, resetn_in = 0, access_req_in = 0, write_in = 0, shift_reg_load_req_in = 0, clr = 0;
  logic col_enable_first_n_in = 1, program_load_n_in = 1, refresh_inhibit_n_in = 0, refresh_request_n_in = 1;
  logic [10:0] row_addr_in = 11'h000, col_addr_in = 11'h000;
  logic [3:0] row_sel_in = 4'hF, col_sel_in = 4'hF;
  wire [10:0] mem_addr_out, cap_row, cap_col;
  wire [3:0] row_strobe_n_out, col_strobe_n_out;
  wire transfer_output_enable_n_out, refresh_status_n_out, access_busy_out, oe_fall, oe_rise, oe_low, oe_fault;
  int fails = 0, comparisons = 0;
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC = 30;

  // Short intervals keep the run brief
  vsr_ctrl #(.REF_CYC_SHORT(SHORT_CYC), .REF_CYC_LONG(LONG_CYC)) dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .row_addr_in(row_addr_in), .col_addr_in(col_addr_in), .access_req_in(access_req_in), .write_in(write_in),
    .shift_reg_load_req_in(shift_reg_load_req_in), .row_sel_in(row_sel_in), .col_sel_in(col_sel_in),
    .col_enable_first_n_in(col_enable_first_n_in), .program_load_n_in(program_load_n_in),
    .refresh_inhibit_n_in(refresh_inhibit_n_in), .refresh_request_n_in(refresh_request_n_in),
    .mem_addr_out(mem_addr_out), .row_strobe_n_out(row_strobe_n_out), .col_strobe_n_out(col_strobe_n_out),
    .transfer_output_enable_n_out(transfer_output_enable_n_out), .refresh_status_n_out(refresh_status_n_out),
    .access_busy_out(access_busy_out));
  vsr_vram_model vram (.clock_in(clock_in), .clr_in(clr), .mem_addr_in(mem_addr_out),
    .row_strobe_n_in(row_strobe_n_out), .col_strobe_n_in(col_strobe_n_out), .oe_n_in(transfer_output_enable_n_out),
    .row_out(cap_row), .col_out(cap_col), .oe_at_fall_out(oe_fall), .oe_at_rise_out(oe_rise),
    .oe_low_out(oe_low), .oe_fault_out(oe_fault));

  initial forever #2 clock_in = ~clock_in;

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  function automatic logic cond(input int c);
    case (c)
      0: return row_strobe_n_out != 4'hF;
      1: return col_strobe_n_out != 4'hF;
      2: return refresh_status_n_out === 1'b0;
      3: return row_strobe_n_out == 4'hF;
      default: return refresh_status_n_out === 1'b1;
    endcase
  endfunction
  // Bounded wait; running out ends the run
  task automatic await(input int c);
    int i;
    for (i = 0; i < 200 && !cond(c); i++) tick(1);
    if (!cond(c)) begin
      fails++;
      $display("Error wait %0d expected 1 seen 0", c);
      close_out();
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Mode load with the first column enable and interval bit on the pins
  task automatic prog(input logic cef_n, input logic lng);
    program_load_n_in = 0;
    col_enable_first_n_in = cef_n;
    row_addr_in = lng ? 11'h5A5 : 11'h5A4;
    tick(6);
    program_load_n_in = 1;
    tick(6);
  endtask
  task automatic access(input logic wr, input logic xf, input logic [10:0] r, input logic [10:0] c);
    row_addr_in = r;
    col_addr_in = c;
    write_in = wr;
    shift_reg_load_req_in = xf;
    clr = 1;
    tick(1);
    clr = 0;
    access_req_in = 1;
    await(0);
    check("busy", access_busy_out, 1);
    tick(1);
    check("row_addr", cap_row, r);
    check("oe_at_row_fall", oe_fall, !xf);
    if (!xf) begin
      await(1);
      tick(4);
      check("col_addr", cap_col, c);
      check("oe_in_access", transfer_output_enable_n_out, wr);
    end
    access_req_in = 0;
    await(3);
    tick(3);
    if (xf) check("oe_at_row_rise", oe_rise, 1);
    check("idle_after", access_busy_out, 0);
    if (wr) check("oe_low_in_write", oe_low, 0);
    check("oe_order", oe_fault, 0);
    $display("access test done");
  endtask
  task automatic refresh_flag();
    prog(0, 0);
    col_enable_first_n_in = 1; // Load is high, so the mode must not follow
    refresh_inhibit_n_in = 1;
    await(2);
    await(0);
    check("flag_ahead", refresh_status_n_out, 0);
    check("ref_rows", row_strobe_n_out, vsr_pkg::STROBE_ALL);
    check("ref_cols", col_strobe_n_out, vsr_pkg::STROBE_IDLE);
    tick(1);
    check("ref_addr_host", cap_row === row_addr_in, 0);
    await(3);
    await(4);
    refresh_request_n_in = 0;
    tick(4);
    refresh_request_n_in = 1;
    await(0);
    tick(1);
    check("ref_row_cleared", cap_row, 11'h000);
    refresh_inhibit_n_in = 0;
    tick(4);
    $display("flag refresh test done");
  endtask
  task automatic refresh_external();
    int n;
    prog(1, 1);
    await(2);
    check("no_internal", row_strobe_n_out, vsr_pkg::STROBE_IDLE);
    tick(1);
    n = 1;
    while (n < 100 && refresh_status_n_out !== 1'b0) begin
      tick(1);
      n++;
    end
    check("long_interval", n, LONG_CYC);
    refresh_request_n_in = 0;
    await(0);
    check("ext_rows", row_strobe_n_out, vsr_pkg::STROBE_ALL);
    refresh_request_n_in = 1;
    await(3);
    $display("external refresh test done");
  endtask

  initial begin
    tick(20);
    check("reset_rows", row_strobe_n_out, 4'hF);
    check("reset_oe", transfer_output_enable_n_out, 1);
    check("reset_status", refresh_status_n_out, 1);
    resetn_in = 1;
    tick(4);
    prog(1, 0);
    access(0, 0, 11'h2C3, 11'h13A);
    access(1, 0, 11'h7FF, 11'h001);
    access(0, 1, 11'h400, 11'h3FF);
    refresh_flag();
    refresh_external();
    close_out();
  end
endmodule
